// ### fcc_pkg.sv
// Shared constants, register layout and checksum helpers for the frame checksum block.
// Assumes a 125 MHz device clock and a 32-bit APB register bus.
package fcc_pkg;

  // Timing
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned ETU_NS = 9440;
  localparam int unsigned ETU_CYCLES = ETU_NS / CLK_PERIOD_NS;

  // Register indices; byte address is four times the index
  localparam logic [9:0] TX_CFG_IDX = 10'h02C;
  localparam logic [9:0] RX_CFG_IDX = 10'h02D;
  localparam logic [9:0] TX_BITS_IDX = 10'h02E;
  localparam logic [9:0] STATUS_IDX = 10'h030;
  localparam logic [9:0] MASK_IDX = 10'h031;
  localparam logic [11:0] TX_CFG_ADDR = {TX_CFG_IDX, 2'b00};
  localparam logic [11:0] RX_CFG_ADDR = {RX_CFG_IDX, 2'b00};
  localparam logic [11:0] TX_BITS_ADDR = {TX_BITS_IDX, 2'b00};
  localparam logic [11:0] STATUS_ADDR = {STATUS_IDX, 2'b00};
  localparam logic [11:0] MASK_ADDR = {MASK_IDX, 2'b00};

  // Reset values
  localparam logic [7:0] TX_CFG_RST = 8'h00;
  localparam logic [7:0] RX_CFG_RST = 8'h00;
  localparam logic [7:0] TX_BITS_RST = 8'h00;
  localparam logic [2:0] STATUS_RST = 3'h0;
  localparam logic [2:0] MASK_RST = 3'h0;

  // Status and mask bit positions
  localparam int unsigned ST_TX_DONE = 0;
  localparam int unsigned ST_RX_DONE = 1;
  localparam int unsigned ST_CRC_ERR = 2;

  // Reflected generator polynomials, LSB-first shifting
  localparam logic [15:0] POLY16_REFL = 16'h8408;
  localparam logic [15:0] POLY8_REFL = 16'h00B8;
  localparam logic [15:0] POLY5_REFL = 16'h0012;

  typedef enum logic [1:0] {
    FCC_W5 = 2'h0,
    FCC_W8 = 2'h1,
    FCC_W16 = 2'h2,
    FCC_WRSV = 2'h3
  } fcc_width_t;

  typedef struct packed {
    logic rsvd;
    logic [2:0] outgoing_seed_select;
    fcc_width_t outgoing_checksum_width;
    logic outgoing_checksum_complement;
    logic append_checksum;
  } fcc_tx_cfg_t;

  typedef struct packed {
    logic store_received_checksum;
    logic [2:0] incoming_seed_select;
    fcc_width_t incoming_checksum_width;
    logic incoming_checksum_complement;
    logic verify_received_checksum;
  } fcc_rx_cfg_t;

  typedef struct packed {
    logic [2:0] rsvd;
    logic align_to_etu_grid;
    logic send_payload;
    logic [2:0] final_byte_bit_count;
  } fcc_tx_bits_t;

  // Reserved width code behaves as the 16-bit checksum
  function automatic logic [4:0] fcc_width_bits(input fcc_width_t w);
    unique case (w)
      FCC_W5: fcc_width_bits = 5'h05;
      FCC_W8: fcc_width_bits = 5'h08;
      default: fcc_width_bits = 5'h10;
    endcase
  endfunction : fcc_width_bits

  function automatic logic [15:0] fcc_mask(input fcc_width_t w);
    unique case (w)
      FCC_W5: fcc_mask = 16'h001F;
      FCC_W8: fcc_mask = 16'h00FF;
      default: fcc_mask = 16'hFFFF;
    endcase
  endfunction : fcc_mask

  // Seed table; undefined codes load zero
  function automatic logic [15:0] fcc_seed(input fcc_width_t w, input logic [2:0] sel,
                                           input logic [15:0] user16, input logic [7:0] user8,
                                           input logic [4:0] user5);
    fcc_seed = 16'h0000;
    unique case (w)
      FCC_W5: begin
        case (sel)
          3'h1: fcc_seed = 16'h0012;
          3'h6: fcc_seed = {11'h000, user5};
          3'h7: fcc_seed = 16'h001F;
          default: fcc_seed = 16'h0000;
        endcase
      end
      FCC_W8: begin
        case (sel)
          3'h1: fcc_seed = 16'h0012;
          3'h2: fcc_seed = 16'h00BF;
          3'h3: fcc_seed = 16'h00FD;
          3'h6: fcc_seed = {8'h00, user8};
          3'h7: fcc_seed = 16'h00FF;
          default: fcc_seed = 16'h0000;
        endcase
      end
      default: begin
        case (sel)
          3'h1: fcc_seed = 16'h6363;
          3'h2: fcc_seed = 16'hA671;
          3'h3: fcc_seed = 16'hFFFE;
          3'h6: fcc_seed = user16;
          3'h7: fcc_seed = 16'hFFFF;
          default: fcc_seed = 16'h0000;
        endcase
      end
    endcase
  endfunction : fcc_seed

  // One LSB-first step of the reflected shift register
  function automatic logic [15:0] fcc_crc_step(input fcc_width_t w, input logic [15:0] crc,
                                               input logic b);
    logic [15:0] poly;
    poly = (w == FCC_W5) ? POLY5_REFL : ((w == FCC_W8) ? POLY8_REFL : POLY16_REFL);
    fcc_crc_step = (crc >> 1) ^ ((crc[0] ^ b) ? poly : 16'h0000);
  endfunction : fcc_crc_step

endpackage : fcc_pkg

// ### fcc_frame_crc.sv
// Frame checksum generation and checking with transmit bit framing, APB register slave.
// Assumes byte source, bit sink and receive bit stream all synchronous to pclk.
//
// What this block does
// - With append_checksum set a checksum is computed and sent after the payload, else none.
// - Width code 0 selects the 5-bit, 1 the 8-bit and 2 the 16-bit checksum; 3 is reserved.
// - With outgoing_checksum_complement set the checksum is inverted before it is sent.
// - outgoing_seed_select in bits 6 to 4 picks the seed loaded before each outgoing frame.
// - 16-bit seeds are 0000h, 6363h, A671h, FFFEh for codes 0 to 3 and FFFFh for code 7.
// - 8-bit and 5-bit seeds follow their own table, the same for both directions.
// - Seed code 6 takes a user seed from nonvolatile storage for the chosen width.
// - With store_received_checksum set received checksum bits go to the FIFO, else not.
// - incoming_seed_select in bits 6 to 4 picks the receive seed from the same table.
// - With incoming_checksum_complement set the received value is checked against the inverse.
// - With verify_received_checksum set a mismatch sets the error flag, else it is untouched.
// - With align_to_etu_grid set frames start only at whole elementary time units apart.
// - With send_payload clear only a single symbol is sent, with it set frame data is sent.
// - final_byte_bit_count sets how many bits of the last byte go out; zero sends all eight.
// - Bytes go out LSB first and a short last byte drops its high-order bits.
`timescale 1ns/1ps
module fcc_frame_crc #(
  parameter int unsigned ETU_CYCLES = fcc_pkg::ETU_CYCLES
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Seeds from nonvolatile storage
  input wire logic [15:0] nv_seed16,
  input wire logic [7:0] nv_seed8,
  input wire logic [4:0] nv_seed5,
  // Outgoing byte source
  input wire logic tx_start,
  input wire logic tx_byte_valid,
  input wire logic [7:0] tx_byte,
  input wire logic tx_byte_last,
  output logic tx_byte_ready,
  // Outgoing bit stream
  output logic tx_bit,
  output logic tx_bit_strobe,
  output logic tx_symbol,
  output logic tx_busy,
  // Incoming bit stream
  input wire logic rx_start,
  input wire logic rx_bit_valid,
  input wire logic rx_bit,
  input wire logic rx_end,
  // Incoming bytes toward the FIFO
  output logic rx_byte_valid,
  output logic [7:0] rx_byte,
  output logic [2:0] rx_byte_bits,
  output logic rx_byte_last,
  // Interrupt
  output logic irq
);

  typedef enum logic [4:0] {
    FCC_IDLE = 5'b00001,
    FCC_GRID = 5'b00010,
    FCC_DATA = 5'b00100,
    FCC_CRC = 5'b01000,
    FCC_SYM = 5'b10000
  } fcc_tx_state_t;

  ////////////////////////////////////////////////////////////////////////////////
  // Register file
  fcc_pkg::fcc_tx_cfg_t tx_cfg;
  fcc_pkg::fcc_rx_cfg_t rx_cfg;
  fcc_pkg::fcc_tx_bits_t tx_bits;
  logic [2:0] status;
  logic [2:0] mask;
  logic [2:0] events;

  wire wr_en = psel & penable & pwrite & pstrb[0];
  wire hit_tx_cfg = paddr == fcc_pkg::TX_CFG_ADDR;
  wire hit_rx_cfg = paddr == fcc_pkg::RX_CFG_ADDR;
  wire hit_tx_bits = paddr == fcc_pkg::TX_BITS_ADDR;
  wire hit_status = paddr == fcc_pkg::STATUS_ADDR;
  wire hit_mask = paddr == fcc_pkg::MASK_ADDR;
  wire hit_any = hit_tx_cfg | hit_rx_cfg | hit_tx_bits | hit_status | hit_mask;
  wire [2:0] w1c = (wr_en & hit_status) ? pwdata[2:0] : 3'h0;
  // Set wins over a clear in the same cycle
  wire [2:0] next_status = (status & ~w1c) | events;
  wire [7:0] rd_byte = hit_tx_cfg ? {1'b0, tx_cfg[6:0]} :
                       hit_rx_cfg ? rx_cfg :
                       hit_tx_bits ? {3'h0, tx_bits[4:0]} :
                       hit_status ? {5'h00, status} :
                       hit_mask ? {5'h00, mask} : 8'h00;

  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit_any;
  assign prdata = {24'h000000, rd_byte};
  assign irq = |(status & mask);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_cfg <= fcc_pkg::fcc_tx_cfg_t'(fcc_pkg::TX_CFG_RST);
      rx_cfg <= fcc_pkg::fcc_rx_cfg_t'(fcc_pkg::RX_CFG_RST);
      tx_bits <= fcc_pkg::fcc_tx_bits_t'(fcc_pkg::TX_BITS_RST);
      mask <= fcc_pkg::MASK_RST;
      status <= fcc_pkg::STATUS_RST;
    end else begin
      if (wr_en && hit_tx_cfg) tx_cfg <= fcc_pkg::fcc_tx_cfg_t'({1'b0, pwdata[6:0]});
      if (wr_en && hit_rx_cfg) rx_cfg <= fcc_pkg::fcc_rx_cfg_t'(pwdata[7:0]);
      if (wr_en && hit_tx_bits) tx_bits <= fcc_pkg::fcc_tx_bits_t'({3'h0, pwdata[4:0]});
      if (wr_en && hit_mask) mask <= pwdata[2:0];
      status <= next_status;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Elementary time unit divider
  fcc_tx_state_t tx_state;
  fcc_pkg::fcc_tx_cfg_t tcfg_l;
  fcc_pkg::fcc_tx_bits_t tbits_l;
  logic [15:0] etu_cnt;
  wire etu_tick = etu_cnt == 16'(ETU_CYCLES - 1);
  wire go_now = (tx_state == FCC_IDLE) & tx_start & ~tx_bits.align_to_etu_grid;
  wire go_grid = (tx_state == FCC_GRID) & etu_tick;
  wire tx_go = go_now | go_grid;
  wire go_payload = go_now ? tx_bits.send_payload : tbits_l.send_payload;

  // Unaligned start restarts the grid, so the first bit still lasts a full unit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) etu_cnt <= 16'h0000;
    else if (go_now || etu_tick) etu_cnt <= 16'h0000;
    else etu_cnt <= etu_cnt + 16'h0001;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Transmit sequencer
  logic [7:0] tx_sr;
  logic [3:0] bits_left;
  logic have_byte;
  logic last_byte;
  logic [15:0] tx_crc;
  logic [15:0] crc_sr;
  logic [4:0] crc_left;

  wire fcc_pkg::fcc_tx_cfg_t go_cfg = go_now ? tx_cfg : tcfg_l;
  wire [15:0] tx_seed = fcc_pkg::fcc_seed(go_cfg.outgoing_checksum_width,
                                          go_cfg.outgoing_seed_select,
                                          nv_seed16, nv_seed8, nv_seed5);
  wire [15:0] tx_crc_next = fcc_pkg::fcc_crc_step(tcfg_l.outgoing_checksum_width,
                                                  tx_crc, tx_sr[0]);
  wire [15:0] tx_mask = fcc_pkg::fcc_mask(tcfg_l.outgoing_checksum_width);
  wire [15:0] tx_crc_out = (tcfg_l.outgoing_checksum_complement ? ~tx_crc_next : tx_crc_next)
                           & tx_mask;
  wire [3:0] last_len = (tbits_l.final_byte_bit_count == 3'h0) ? 4'h8 :
                        {1'b0, tbits_l.final_byte_bit_count};
  wire tx_load = tx_byte_valid & tx_byte_ready;
  wire data_shift = (tx_state == FCC_DATA) & etu_tick & have_byte;
  wire byte_done = data_shift & (bits_left == 4'h1);
  wire frame_data_end = byte_done & last_byte;
  wire crc_done = (tx_state == FCC_CRC) & etu_tick & (crc_left == 5'h01);
  wire sym_done = (tx_state == FCC_SYM) & etu_tick;
  wire nodata_end = frame_data_end & ~tcfg_l.append_checksum;
  wire tx_done = crc_done | sym_done | nodata_end;

  assign tx_byte_ready = (tx_state == FCC_DATA) & ~have_byte;
  assign tx_busy = tx_state != FCC_IDLE;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_state <= FCC_IDLE;
      tcfg_l <= fcc_pkg::fcc_tx_cfg_t'(fcc_pkg::TX_CFG_RST);
      tbits_l <= fcc_pkg::fcc_tx_bits_t'(fcc_pkg::TX_BITS_RST);
    end else begin
      if (tx_state == FCC_IDLE && tx_start) begin
        tcfg_l <= tx_cfg;
        tbits_l <= tx_bits;
      end
      unique case (tx_state)
        FCC_IDLE: begin
          if (tx_start && tx_bits.align_to_etu_grid) tx_state <= FCC_GRID;
          else if (go_now) tx_state <= tx_bits.send_payload ? FCC_DATA : FCC_SYM;
        end
        FCC_GRID: if (go_grid) tx_state <= go_payload ? FCC_DATA : FCC_SYM;
        FCC_DATA: begin
          if (frame_data_end) tx_state <= tcfg_l.append_checksum ? FCC_CRC : FCC_IDLE;
        end
        FCC_CRC: if (crc_done) tx_state <= FCC_IDLE;
        FCC_SYM: if (sym_done) tx_state <= FCC_IDLE;
        default: tx_state <= FCC_IDLE;
      endcase
    end
  end

  // Byte shifter and checksum; a late byte simply stalls the bit clock slot
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_sr <= 8'h00;
      bits_left <= 4'h0;
      have_byte <= 1'b0;
      last_byte <= 1'b0;
      tx_crc <= 16'h0000;
      crc_sr <= 16'h0000;
      crc_left <= 5'h00;
      tx_bit <= 1'b0;
      tx_bit_strobe <= 1'b0;
      tx_symbol <= 1'b0;
    end else begin
      tx_bit_strobe <= data_shift | ((tx_state == FCC_CRC) & etu_tick);
      tx_symbol <= sym_done;
      if (tx_go) begin
        tx_crc <= tx_seed;
        have_byte <= 1'b0;
      end else if (tx_load) begin
        tx_sr <= tx_byte;
        last_byte <= tx_byte_last;
        bits_left <= tx_byte_last ? last_len : 4'h8;
        have_byte <= 1'b1;
      end else if (data_shift) begin
        tx_bit <= tx_sr[0];
        tx_sr <= {1'b0, tx_sr[7:1]};
        tx_crc <= tx_crc_next;
        bits_left <= bits_left - 4'h1;
        if (byte_done) have_byte <= 1'b0;
        if (frame_data_end) begin
          crc_sr <= tx_crc_out;
          crc_left <= fcc_pkg::fcc_width_bits(tcfg_l.outgoing_checksum_width);
        end
      end else if (tx_state == FCC_CRC && etu_tick) begin
        tx_bit <= crc_sr[0];
        crc_sr <= {1'b0, crc_sr[15:1]};
        crc_left <= crc_left - 5'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Receive checker
  // The newest W bits are held back as a possible checksum; older bits are data.
  fcc_pkg::fcc_rx_cfg_t rcfg_l;
  logic [15:0] rx_win;
  logic [4:0] rx_fill;
  logic [15:0] rx_crc;
  logic [7:0] asm_sr;
  logic [2:0] asm_cnt;

  wire [4:0] rx_w = fcc_pkg::fcc_width_bits(rcfg_l.incoming_checksum_width);
  wire [4:0] rx_sel = 5'h10 - rx_w;
  wire exit_bit = rx_win[rx_sel[3:0]];
  wire window_full = rx_fill >= rx_w;
  wire crc_in = rx_bit_valid & window_full;
  wire store = rcfg_l.store_received_checksum;
  wire out_valid = rx_bit_valid & (store | window_full);
  wire out_bit = store ? rx_bit : exit_bit;
  wire [15:0] rx_mask = fcc_pkg::fcc_mask(rcfg_l.incoming_checksum_width);
  wire [15:0] rx_recv = (rx_win >> rx_sel) & rx_mask;
  wire [15:0] rx_expect = (rcfg_l.incoming_checksum_complement ? ~rx_crc : rx_crc)
                          & rx_mask;
  wire rx_mismatch = (rx_recv != rx_expect) | ~window_full;
  wire [15:0] rx_seed = fcc_pkg::fcc_seed(rx_cfg.incoming_checksum_width,
                                          rx_cfg.incoming_seed_select,
                                          nv_seed16, nv_seed8, nv_seed5);
  wire byte_full = out_valid & (asm_cnt == 3'h7);
  wire flush = rx_end & (asm_cnt != 3'h0);

  assign events[fcc_pkg::ST_TX_DONE] = tx_done;
  assign events[fcc_pkg::ST_RX_DONE] = rx_end;
  assign events[fcc_pkg::ST_CRC_ERR] = rx_end & rcfg_l.verify_received_checksum
                                       & rx_mismatch;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rcfg_l <= fcc_pkg::fcc_rx_cfg_t'(fcc_pkg::RX_CFG_RST);
      rx_win <= 16'h0000;
      rx_fill <= 5'h00;
      rx_crc <= 16'h0000;
    end else if (rx_start) begin
      rcfg_l <= rx_cfg;
      rx_fill <= 5'h00;
      rx_crc <= rx_seed;
    end else if (rx_bit_valid) begin
      rx_win <= {rx_bit, rx_win[15:1]};
      if (!rx_fill[4]) rx_fill <= rx_fill + 5'h01;
      if (crc_in) rx_crc <= fcc_pkg::fcc_crc_step(rcfg_l.incoming_checksum_width,
                                                   rx_crc, exit_bit);
    end
  end

  // Byte assembly, LSB first; a short last byte is right-aligned
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      asm_sr <= 8'h00;
      asm_cnt <= 3'h0;
      rx_byte_valid <= 1'b0;
      rx_byte <= 8'h00;
      rx_byte_bits <= 3'h0;
      rx_byte_last <= 1'b0;
    end else begin
      rx_byte_valid <= byte_full | flush;
      rx_byte_last <= flush;
      if (rx_start) begin
        asm_cnt <= 3'h0;
      end else if (flush) begin
        rx_byte <= asm_sr >> (4'h8 - {1'b0, asm_cnt});
        rx_byte_bits <= asm_cnt;
        asm_cnt <= 3'h0;
      end else if (out_valid) begin
        asm_sr <= {out_bit, asm_sr[7:1]};
        asm_cnt <= asm_cnt + 3'h1;
        if (byte_full) begin
          rx_byte <= {out_bit, asm_sr[7:1]};
          rx_byte_bits <= 3'h0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  localparam int GAP_LAST = ETU_CYCLES - 1;
  logic [15:0] go_gap;
  logic seen_go;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      go_gap <= 16'h0000;
      seen_go <= 1'b0;
    end else begin
      seen_go <= seen_go | tx_go;
      go_gap <= (tx_go || go_gap == 16'(GAP_LAST)) ? 16'h0000 : go_gap + 16'h0001;
    end
  end

  property p_crc_follows;
    frame_data_end && tcfg_l.append_checksum |=> tx_state == FCC_CRC;
  endproperty
  a_crc_follows: assert property (p_crc_follows) else $error("no checksum after data");

  property p_no_crc;
    frame_data_end && !tcfg_l.append_checksum |=> tx_state == FCC_IDLE ##1 !tx_bit_strobe;
  endproperty
  a_no_crc: assert property (p_no_crc) else $error("checksum sent while disabled");

  property p_crc_len;
    $rose(tx_state == FCC_CRC) |->
      crc_left == fcc_pkg::fcc_width_bits(tcfg_l.outgoing_checksum_width);
  endproperty
  a_crc_len: assert property (p_crc_len) else $error("wrong checksum length");

  property p_crc_inv;
    frame_data_end |=> crc_sr == ((tcfg_l.outgoing_checksum_complement ?
      ~$past(tx_crc_next) : $past(tx_crc_next)) & tx_mask);
  endproperty
  a_crc_inv: assert property (p_crc_inv) else $error("checksum inversion wrong");

  property p_seed;
    tx_go |=> tx_crc == $past(tx_seed);
  endproperty
  a_seed: assert property (p_seed) else $error("seed not loaded at frame start");

  property p_store;
    rx_bit_valid && store && asm_cnt == 3'h7 && !rx_start |=> rx_byte_valid && !rx_byte_last;
  endproperty
  a_store: assert property (p_store) else $error("stored byte missing");

  property p_err_quiet;
    rx_end && !rcfg_l.verify_received_checksum && w1c == 3'h0 |=>
      status[fcc_pkg::ST_CRC_ERR] == $past(status[fcc_pkg::ST_CRC_ERR]);
  endproperty
  a_err_quiet: assert property (p_err_quiet) else $error("error flag touched");

  property p_err_set;
    rx_end && rcfg_l.verify_received_checksum && rx_mismatch |=>
      status[fcc_pkg::ST_CRC_ERR];
  endproperty
  a_err_set: assert property (p_err_set) else $error("mismatch not flagged");

  property p_grid;
    go_grid && seen_go |-> go_gap == 16'(GAP_LAST);
  endproperty
  a_grid: assert property (p_grid) else $error("start off the time grid");

  property p_symbol;
    tx_go && !go_payload |=> tx_state == FCC_SYM;
  endproperty
  a_symbol: assert property (p_symbol) else $error("payload sent in symbol mode");

  property p_last_len;
    tx_load && tx_byte_last |=> bits_left == last_len;
  endproperty
  a_last_len: assert property (p_last_len) else $error("last byte length wrong");

  c_crc_frame: cover property (crc_done);
  c_symbol: cover property (sym_done);
  c_grid: cover property (go_grid && seen_go);
  c_err: cover property (events[fcc_pkg::ST_CRC_ERR]);

endmodule : fcc_frame_crc

// ### fcc_card_model.sv
// Card-side model: records reader bits and sends frames back to the reader.
// Assumes bits arrive one per strobe and that every drive follows a pclk edge.
`timescale 1ns/1ps
module fcc_card_model (
  // Clock
  input wire logic pclk,
  // Reader to card
  input wire logic tx_bit,
  input wire logic tx_bit_strobe,
  // Card to reader
  output logic rx_start,
  output logic rx_bit_valid,
  output logic rx_bit,
  output logic rx_end,
  // Captured frame
  output logic [63:0] cap,
  output logic [6:0] cap_n
);
  initial begin
    {rx_start, rx_bit_valid, rx_bit, rx_end, cap, cap_n} = '0;
  end
  always @(posedge pclk) begin
    if (tx_bit_strobe) begin
      cap[cap_n] <= tx_bit;
      cap_n <= cap_n + 7'h01;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // Line toggles between bits so a stale value is never mistaken for data
  task automatic send(input logic [31:0] d, input int n);
    @(posedge pclk) rx_start <= 1'b1;
    @(posedge pclk) rx_start <= 1'b0;
    for (int i = 0; i < n; i++) begin
      @(posedge pclk);
      rx_bit_valid <= 1'b1;
      rx_bit <= d[i];
      @(posedge pclk);
      rx_bit_valid <= 1'b0;
      rx_bit <= ~d[i];
    end
    @(posedge pclk) rx_end <= 1'b1;
    @(posedge pclk) rx_end <= 1'b0;
  endtask : send
endmodule : fcc_card_model

// ### fcc_frame_crc_tb.sv
// Self-checking bench for the frame checksum block.
// Assumes 8 ns pclk, short elementary time unit and zero-wait APB.
`timescale 1ns/1ps
module fcc_frame_crc_tb;
  logic pclk, presetn, psel, penable, pwrite, slv;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic pready, pslverr, tx_start, tx_byte_valid, tx_byte_last, tx_byte_ready;
  logic [7:0] tx_byte, rx_byte;
  logic tx_bit, tx_bit_strobe, tx_symbol, tx_busy, rx_start, rx_bit_valid, rx_bit, rx_end;
  logic rx_byte_valid, rx_byte_last, irq;
  logic [2:0] rx_byte_bits;
  logic [63:0] cap;
  logic [6:0] cap_n;
  logic [15:0] c;
  int err_total = 0;
  int n_tests = 0;
  fcc_frame_crc #(.ETU_CYCLES(4)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .nv_seed16(16'h1234),
    .nv_seed8(8'h5C), .nv_seed5(5'h0A), .tx_start(tx_start), .tx_byte_valid(tx_byte_valid),
    .tx_byte(tx_byte), .tx_byte_last(tx_byte_last), .tx_byte_ready(tx_byte_ready),
    .tx_bit(tx_bit), .tx_bit_strobe(tx_bit_strobe), .tx_symbol(tx_symbol), .tx_busy(tx_busy),
    .rx_start(rx_start), .rx_bit_valid(rx_bit_valid), .rx_bit(rx_bit), .rx_end(rx_end),
    .rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte), .rx_byte_bits(rx_byte_bits),
    .rx_byte_last(rx_byte_last), .irq(irq));
  fcc_card_model card (.pclk(pclk), .tx_bit(tx_bit), .tx_bit_strobe(tx_bit_strobe),
    .rx_start(rx_start), .rx_bit_valid(rx_bit_valid), .rx_bit(rx_bit), .rx_end(rx_end),
    .cap(cap), .cap_n(cap_n));
  // Output monitors: received bytes toward the FIFO and symbol pulses
  logic [11:0] rx_got;
  int rx_nb = 0;
  int n_sym = 0;
  always @(posedge pclk) begin
    if (rx_byte_valid === 1'b1) begin
      rx_got <= {rx_byte_last, rx_byte_bits, rx_byte};
      rx_nb <= rx_nb + 1;
    end
    if (tx_symbol === 1'b1) n_sym <= n_sym + 1;
  end
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("Checks %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : final_report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk) penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    r = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 20) begin
      err_total++;
      final_report();
    end
  endtask : apb
  // Reference checksum, reflected register shifted LSB first
  function automatic logic [15:0] crc_ref(input logic [15:0] poly, input logic [15:0] seed,
                                          input logic [31:0] d, input int n);
    crc_ref = seed;
    for (int i = 0; i < n; i++) crc_ref = (crc_ref >> 1) ^ ((crc_ref[0] ^ d[i]) ? poly : 16'h0);
  endfunction : crc_ref
  ////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    apb(1'b1, fcc_pkg::TX_CFG_ADDR, 32'hFF);
    apb(1'b0, fcc_pkg::TX_CFG_ADDR, 32'h0);
    chk(r, 32'h7F);
    apb(1'b1, fcc_pkg::TX_BITS_ADDR, 32'hFF);
    apb(1'b0, fcc_pkg::TX_BITS_ADDR, 32'h0);
    chk(r, 32'h1F);
    apb(1'b0, 12'h000, 32'h0);
    chk({31'h0, slv}, 32'h1);
    $display("regs test done");
  endtask : t_regs
  // Three-bit last byte, 8-bit checksum from seed 12h, inverted
  task automatic t_tx();
    int k;
    apb(1'b1, fcc_pkg::TX_CFG_ADDR, 32'h17);
    apb(1'b1, fcc_pkg::TX_BITS_ADDR, 32'h0B);
    apb(1'b1, fcc_pkg::MASK_ADDR, 32'h1);
    @(posedge pclk);
    tx_start <= 1'b1;
    tx_byte_valid <= 1'b1;
    tx_byte <= 8'hB2;
    tx_byte_last <= 1'b1;
    @(posedge pclk) tx_start <= 1'b0;
    k = 0;
    while (tx_byte_ready !== 1'b1 && k < 50) begin
      @(posedge pclk);
      k++;
    end
    tx_byte_valid <= 1'b0;
    while (tx_busy !== 1'b0 && k < 500) begin
      @(posedge pclk);
      k++;
    end
    // Let the card take the last checksum bit
    @(posedge pclk);
    if (k >= 500) begin
      err_total++;
      final_report();
    end
    c = crc_ref(fcc_pkg::POLY8_REFL, 16'h0012, 32'h2, 3) ^ 16'h00FF;
    chk({29'h0, cap[2:0]}, 32'h2);
    chk({24'h0, cap[10:3]}, {16'h0, c});
    chk({25'h0, cap_n}, 32'd11);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, fcc_pkg::STATUS_ADDR, 32'h7);
    @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    $display("tx test done");
  endtask : t_tx
  // 16-bit checksum from seed FFFFh, good frame then corrupted frame
  task automatic t_rx();
    apb(1'b1, fcc_pkg::RX_CFG_ADDR, 32'h79);
    c = crc_ref(fcc_pkg::POLY16_REFL, 16'hFFFF, 32'h5A, 8);
    card.send({8'h0, c, 8'h5A}, 24);
    apb(1'b0, fcc_pkg::STATUS_ADDR, 32'h0);
    chk(r, 32'h2);
    chk({20'h0, rx_got}, 32'h05A);
    apb(1'b1, fcc_pkg::STATUS_ADDR, 32'h7);
    card.send({8'h0, c ^ 16'h0001, 8'h5A}, 24);
    apb(1'b0, fcc_pkg::STATUS_ADDR, 32'h0);
    chk(r, 32'h6);
    apb(1'b1, fcc_pkg::STATUS_ADDR, 32'h7);
    // 5-bit checksum is stored since store_received_checksum is set, giving a 5-bit last byte; check disabled
    apb(1'b1, fcc_pkg::RX_CFG_ADDR, 32'hF0);
    c = crc_ref(fcc_pkg::POLY5_REFL, 16'h001F, 32'h5A, 8);
    card.send({8'h0, c ^ 16'h0001, 8'h5A}, 13);
    apb(1'b0, fcc_pkg::STATUS_ADDR, 32'h0);
    chk(r, 32'h2);
    chk({20'h0, rx_got}, {20'h0, 1'b1, 3'h5, 3'h0, c[4:0] ^ 5'h01});
    chk(rx_nb, 32'd4);
    $display("rx test done");
  endtask : t_rx
  // Symbol only, started on the time grid
  task automatic t_sym();
    int k;
    apb(1'b1, fcc_pkg::TX_BITS_ADDR, 32'h10);
    @(posedge pclk) tx_start <= 1'b1;
    @(posedge pclk) tx_start <= 1'b0;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (tx_busy !== 1'b0 && k < 100);
    @(posedge pclk);
    if (k >= 100) begin
      err_total++;
      final_report();
    end
    chk(n_sym, 32'd1);
    chk({25'h0, cap_n}, 32'd11);
    $display("symbol test done");
  endtask : t_sym
  ////////////////////////////////////////////////////////////////////////
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {tx_start, tx_byte_valid, tx_byte, tx_byte_last} = '0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_tx();
    t_rx();
    t_sym();
    final_report();
  end
endmodule : fcc_frame_crc_tb
